// File: alu_consts.svh
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
// ****************
// timing counts
// ****************
`define BASE_LATENCY 3'd1
`define PC_FLUSH_CYCLES 3'd2
`define MISALIGN_CYCLES 3'd1
`define MIN_COND_REV 2'd2
`define SSRF_FWD_LOW_BIT 5'd15
// ****************
// status flag bits and condition codes
// ****************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define COND_EQ 4'h0
`define COND_NE 4'h1
`define COND_CS 4'h2
`define COND_CC 4'h3
`define COND_GE 4'h4
`define COND_LT 4'h5
`define COND_MI 4'h6
`define COND_PL 4'h7
`define COND_LS 4'h8
`define COND_GT 4'h9
`define COND_LE 4'ha
`define COND_HI 4'hb
`define COND_VS 4'hc
`define COND_VC 4'hd
`define COND_QS 4'he
`define COND_AL 4'hf
`endif

// File: alu_pkg.sv
`default_nettype none
package alu_pkg;
  typedef enum logic [4:0] {
    OP_ABS = 5'h00, OP_ACR = 5'h01, OP_ADC = 5'h02, OP_ADD = 5'h03, OP_ADD_COND = 5'h04,
    OP_ADDHH = 5'h05, OP_ADDABS = 5'h06, OP_CP_B = 5'h07, OP_CP_H = 5'h08, OP_CP_W = 5'h09,
    OP_CPC = 5'h0a, OP_MAX = 5'h0b, OP_MIN = 5'h0c, OP_NEG = 5'h0d, OP_RSUB = 5'h0e,
    OP_RSUB_COND = 5'h0f, OP_SBC = 5'h10, OP_SCR = 5'h11, OP_SUB = 5'h12, OP_SSRF = 5'h13
  } alu_op_t;
  typedef enum logic [2:0] {
    ST_ISSUE = 3'b001,
    ST_FLUSH = 3'b010,
    ST_FETCH2 = 3'b100
  } issue_state_t;
endpackage
`default_nettype wire

// File: alu_core.sv
`include "alu_consts.svh"
`default_nettype none
module alu_core (
  input wire alu_pkg::alu_op_t op, // operation
  input wire logic [31:0] rx, // first source / destination old value
  input wire logic [31:0] ry, // second source or immediate
  input wire logic [3:0] flags, // v n z c
  input wire logic [3:0] cond, // condition field
  input wire logic part_x, // addhh halfword select of rx
  input wire logic part_y, // addhh halfword select of ry
  output logic [31:0] res, // result
  output logic [3:0] flags_out, // new flags
  output logic wr_en // destination written
);
  import alu_pkg::*;
  logic [32:0] sum;
  logic [31:0] a, b;
  logic cin, is_sub, cmp;
  logic [31:0] sx, sy;
  logic cond_ok;
  logic c, z, n, v;
  assign c = flags[`FLAG_C];
  assign z = flags[`FLAG_Z];
  assign n = flags[`FLAG_N];
  assign v = flags[`FLAG_V];
  assign sx = part_x ? {{16{rx[31]}}, rx[31:16]} : {{16{rx[15]}}, rx[15:0]};
  assign sy = part_y ? {{16{ry[31]}}, ry[31:16]} : {{16{ry[15]}}, ry[15:0]};
  always_comb begin
    unique case (cond)
      `COND_EQ: cond_ok = z;
      `COND_NE: cond_ok = !z;
      `COND_CS: cond_ok = c;
      `COND_CC: cond_ok = !c;
      `COND_GE: cond_ok = n == v;
      `COND_LT: cond_ok = n != v;
      `COND_MI: cond_ok = n;
      `COND_PL: cond_ok = !n;
      `COND_LS: cond_ok = c | z;
      `COND_GT: cond_ok = !z & (n == v);
      `COND_LE: cond_ok = z | (n != v);
      `COND_HI: cond_ok = !c & !z;
      `COND_VS: cond_ok = v;
      `COND_VC: cond_ok = !v;
      `COND_QS: cond_ok = 1'b0;
      `COND_AL: cond_ok = 1'b1;
    endcase
  end
  // operand steering; subtraction is a + ~b + !borrow
  always_comb begin
    a = rx;
    b = ry;
    cin = 1'b0;
    is_sub = 1'b0;
    cmp = 1'b0;
    wr_en = 1'b1;
    unique case (op)
      // non-negative values pass through as 0 + rx
      OP_ABS: begin a = 32'h0; b = rx; is_sub = rx[31]; cin = rx[31]; end
      OP_NEG: begin a = 32'h0; b = rx; is_sub = 1'b1; cin = 1'b1; end
      OP_ACR: begin b = 32'h0; cin = c; end
      OP_ADC: cin = c;
      OP_ADD: ;
      OP_ADD_COND: wr_en = cond_ok;
      OP_ADDHH: begin a = sx; b = sy; end
      OP_ADDABS: b = ry[31] ? (32'h0 - ry) : ry;
      OP_MAX, OP_MIN: wr_en = 1'b1;
      OP_CP_B: begin a = {rx[7:0], 24'h0}; b = {ry[7:0], 24'h0}; is_sub = 1'b1;
        cin = 1'b1; cmp = 1'b1; end
      OP_CP_H: begin a = {rx[15:0], 16'h0}; b = {ry[15:0], 16'h0}; is_sub = 1'b1;
        cin = 1'b1; cmp = 1'b1; end
      OP_CP_W: begin is_sub = 1'b1; cin = 1'b1; cmp = 1'b1; end
      OP_CPC: begin is_sub = 1'b1; cin = !c; cmp = 1'b1; end
      OP_RSUB: begin a = ry; b = rx; is_sub = 1'b1; cin = 1'b1; end
      OP_RSUB_COND: begin a = ry; b = rx; is_sub = 1'b1; cin = 1'b1;
        wr_en = cond_ok; end
      OP_SBC: begin is_sub = 1'b1; cin = !c; end
      OP_SCR: begin b = 32'h0; is_sub = 1'b1; cin = !c; end
      OP_SUB: begin is_sub = 1'b1; cin = 1'b1; end
      OP_SSRF: begin wr_en = 1'b0; cmp = 1'b1; end
      default: ;
    endcase
    if (cmp) wr_en = 1'b0;
  end
  logic [31:0] bb;
  logic signed_lt, ov;
  assign bb = is_sub ? ~b : b;
  assign sum = {1'b0, a} + {1'b0, bb} + {32'h0, cin};
  assign ov = (a[31] == bb[31]) && (sum[31] != a[31]);
  assign signed_lt = $signed(rx) < $signed(ry);
  always_comb begin
    res = sum[31:0];
    if (op == OP_MAX) res = signed_lt ? ry : rx;
    if (op == OP_MIN) res = signed_lt ? rx : ry;
    flags_out = flags;
    if (op != OP_SSRF) begin
      flags_out[`FLAG_N] = res[31];
      flags_out[`FLAG_V] = ov;
      // adc, sbc and cpc keep zero sticky
      if (op == OP_CPC || op == OP_SBC || op == OP_ADC)
        flags_out[`FLAG_Z] = (res == 32'h0) & z;
      else
        flags_out[`FLAG_Z] = res == 32'h0;
      flags_out[`FLAG_C] = is_sub ? !sum[32] : sum[32];
    end
  end
endmodule
`default_nettype wire

// File: alu_issue_timing.sv
// Function
// - issue is decode-to-execute transfer
// - latency counts cycles between issues
// - pc jump after all effects commit
// - pc write adds two flush cycles
// - halfword-aligned extended target adds one cycle
// - single cycle, forwarded, except high ssrf
// - carry add forms, one cycle
// - carry subtract forms, one cycle
// - conditional add writes only when true
// - signed halfword add into 32 bits
// - add absolute value of second source
// - conditional reverse subtract from immediate
// - same timing, new ops need revision
`include "alu_consts.svh"
`default_nettype none
module alu_issue_timing #(
  parameter int REVISION = 2
) (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic dec_valid, // decode stage holds an instruction
  input wire alu_pkg::alu_op_t dec_op, // operation
  input wire logic [3:0] dec_rd, // destination index
  input wire logic [3:0] dec_rx, // source x index
  input wire logic [3:0] dec_ry, // source y index
  input wire logic dec_use_imm, // second operand is immediate
  input wire logic [31:0] dec_imm, // immediate
  input wire logic [3:0] dec_cond, // condition field
  input wire logic dec_part_x, // halfword select x
  input wire logic dec_part_y, // halfword select y
  input wire logic [4:0] dec_ssrf_bit, // flag bit for ssrf
  input wire logic tgt_ext_misaligned, // jump target is halfword-aligned extended
  output logic dec_ready, // decode may move to execute
  output logic issue, // instruction issued this cycle
  output logic illegal_op, // op absent on this revision
  output logic pc_load, // jump now
  output logic [31:0] pc_target, // jump address
  output logic [31:0] ex_result, // registered result
  output logic [3:0] flags_q, // status flags
  output logic [2:0] issue_latency // latency of last issued instruction
);
  import alu_pkg::*;
  // ****************
  // reset sync
  // ****************
  logic rst_meta_r, rst_n_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end
  // ****************
  // register file, index 15 is pc
  // ****************
  logic [31:0] regs_r [0:15];
  logic [31:0] op_x, op_y, res;
  logic [3:0] fl_nxt;
  logic wr_en, new_op, legal, to_pc, ssrf_slow;
  assign op_x = (dec_op == OP_RSUB_COND || dec_op == OP_NEG || dec_op == OP_ABS ||
                 dec_op == OP_ACR || dec_op == OP_SCR) ? regs_r[dec_rd] : regs_r[dec_rx];
  assign op_y = dec_use_imm ? dec_imm : regs_r[dec_ry];
  alu_core u_core (
    .op(dec_op),
    .rx(op_x),
    .ry(op_y),
    .flags(flags_q),
    .cond(dec_cond),
    .part_x(dec_part_x),
    .part_y(dec_part_y),
    .res(res),
    .flags_out(fl_nxt),
    .wr_en(wr_en)
  );
  assign new_op = dec_op == OP_ADD_COND || dec_op == OP_RSUB_COND;
  assign legal = !(new_op && REVISION < `MIN_COND_REV);
  assign illegal_op = dec_valid && !legal;
  assign to_pc = wr_en && dec_rd == 4'hf;
  assign ssrf_slow = dec_op == OP_SSRF && dec_ssrf_bit >= `SSRF_FWD_LOW_BIT;
  // ****************
  // issue state machine
  // ****************
  issue_state_t st_r, st_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic [2:0] lat_r, lat_nxt;
  logic [31:0] tgt_r;
  assign dec_ready = st_r == ST_ISSUE;
  // nothing moves to execute while the enable is low
  assign issue = ce && dec_ready && dec_valid && legal;
  always_comb begin
    st_nxt = st_r;
    wait_nxt = wait_r;
    lat_nxt = lat_r;
    unique case (st_r)
      ST_ISSUE: if (issue) begin
        lat_nxt = `BASE_LATENCY;
        if (to_pc) begin
          st_nxt = ST_FLUSH;
          wait_nxt = 2'(`PC_FLUSH_CYCLES);
          lat_nxt = `BASE_LATENCY + `PC_FLUSH_CYCLES + (tgt_ext_misaligned ?
                    `MISALIGN_CYCLES : 3'd0);
        end else if (ssrf_slow) begin
          st_nxt = ST_FETCH2;
          lat_nxt = `BASE_LATENCY + 3'd1;
        end
      end
      ST_FLUSH: begin
        wait_nxt = wait_r - 2'd1;
        if (wait_r == 2'd1) st_nxt = tgt_ext_misaligned ? ST_FETCH2 : ST_ISSUE;
      end
      ST_FETCH2: st_nxt = ST_ISSUE;
      default: st_nxt = ST_ISSUE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= ST_ISSUE;
      wait_r <= 2'd0;
      lat_r <= 3'd0;
    end else if (ce) begin
      st_r <= st_nxt;
      wait_r <= wait_nxt;
      lat_r <= lat_nxt;
    end
  end
  assign issue_latency = lat_r;
  // ****************
  // execute commit, result forwarded by the register file
  // ****************
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < 16; i++) regs_r[i] <= 32'h0;
      flags_q <= 4'h0;
      ex_result <= 32'h0;
      tgt_r <= 32'h0;
      pc_load <= 1'b0;
    end else if (ce) begin
      pc_load <= 1'b0;
      if (issue) begin
        if (wr_en) regs_r[dec_rd] <= res;
        flags_q <= fl_nxt;
        ex_result <= res;
        if (to_pc) begin
          tgt_r <= res;
          pc_load <= 1'b1;
        end
      end
    end
  end
  assign pc_target = tgt_r;
  // ****************
  // checks
  // ****************
  property p_flush_len;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (issue && to_pc && !tgt_ext_misaligned) |=> !dec_ready [*2] ##1 dec_ready;
  endproperty
  a_flush_len: assert property (p_flush_len) else $error("pc flush not two cycles");
  property p_misalign;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (st_r == ST_FLUSH && wait_r == 2'd1 && tgt_ext_misaligned) |=> !dec_ready ##1 dec_ready;
  endproperty
  a_misalign: assert property (p_misalign) else $error("no extra fetch cycle");
  property p_single;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (issue && !to_pc && !ssrf_slow) |=> dec_ready && issue_latency == 3'd1;
  endproperty
  a_single: assert property (p_single) else $error("alu op not single cycle");
  property p_jump_after;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (issue && to_pc) |=> pc_load && pc_target == regs_r[15];
  endproperty
  a_jump_after: assert property (p_jump_after) else $error("jump before commit");
  property p_issue_gate;
    @(posedge clk) disable iff (!rst_n_r)
    !issue |=> ex_result == $past(ex_result) && flags_q == $past(flags_q);
  endproperty
  a_issue_gate: assert property (p_issue_gate) else $error("commit without issue");
  property p_lat;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (issue && to_pc && tgt_ext_misaligned) |=> issue_latency == 3'd4;
  endproperty
  a_lat: assert property (p_lat) else $error("latency wrong");
  property p_cmp;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (issue && (dec_op == OP_CP_W || dec_op == OP_CPC)) |=>
      regs_r[$past(dec_rd)] == $past(regs_r[dec_rd]);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrote a register");
  property p_rev;
    @(posedge clk) disable iff (!rst_n_r)
    (REVISION < 2 && new_op) |-> !issue;
  endproperty
  a_rev: assert property (p_rev) else $error("new op issued on old revision");
  property p_neg;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (issue && dec_op == OP_NEG && dec_rd != 4'hf) |=>
      regs_r[$past(dec_rd)] == 32'h0 - $past(regs_r[dec_rd]);
  endproperty
  a_neg: assert property (p_neg) else $error("negate wrong");
  property p_ce_freeze;
    @(posedge clk) disable iff (!rst_n_r)
    !ce |=> st_r == $past(st_r) && lat_r == $past(lat_r) && wait_r == $past(wait_r);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");
  property p_pc_lat;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (issue && to_pc && !tgt_ext_misaligned) |=> issue_latency == 3'd3;
  endproperty
  a_pc_lat: assert property (p_pc_lat) else $error("pc write latency not three");
  property p_cond_skip;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (issue && dec_op == OP_ADD_COND && dec_cond == `COND_QS) |=>
      regs_r[$past(dec_rd)] == $past(regs_r[dec_rd]);
  endproperty
  a_cond_skip: assert property (p_cond_skip) else $error("false add wrote");
  property p_rsub_skip;
    @(posedge clk) disable iff (!rst_n_r || !ce)
    (issue && dec_op == OP_RSUB_COND && dec_cond == `COND_QS) |=>
      regs_r[$past(dec_rd)] == $past(regs_r[dec_rd]);
  endproperty
  a_rsub_skip: assert property (p_rsub_skip) else $error("false rsub wrote");
endmodule
`default_nettype wire

// File: alu_issue_timing_tb.sv
`include "alu_consts.svh"
`default_nettype none
module alu_issue_timing_tb import alu_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, dec_valid = 1'b0, dec_use_imm = 1'b0;
  logic dec_part_x = 1'b0, dec_part_y = 1'b0, tgt_ext_misaligned = 1'b0;
  alu_op_t dec_op = OP_ADD;
  logic [3:0] dec_rd = 4'h0, dec_rx = 4'h0, dec_ry = 4'h0, dec_cond = 4'hf, flags_q;
  logic [31:0] dec_imm = 32'h0, pc_target, ex_result;
  logic [4:0] dec_ssrf_bit = 5'h0;
  logic dec_ready, issue, illegal_op, pc_load, ill1;
  logic [2:0] issue_latency, lat_seen;
  int error_cnt = 0, checks_done = 0, waited;
  alu_op_t ops [23] = '{OP_ADD, OP_SUB, OP_ADC, OP_ACR, OP_SBC, OP_SCR, OP_ADDHH, OP_ADDABS,
    OP_MAX, OP_MIN, OP_NEG, OP_ABS, OP_RSUB, OP_CP_B, OP_CP_H, OP_CP_W, OP_CPC,
    OP_ADD_COND, OP_ADD_COND, OP_ADD_COND, OP_RSUB_COND, OP_RSUB_COND, OP_RSUB_COND};
  logic [3:0] cnd [23] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf,
    4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'he, 4'h2, 4'hf, 4'he, 4'h2};
  // ****************
  // devices under test
  // ****************
  alu_issue_timing #(.REVISION(2)) alu_issue_timing_i (
    .clk(clk), .nrst(nrst), .ce(ce), .dec_valid(dec_valid), .dec_op(dec_op),
    .dec_rd(dec_rd), .dec_rx(dec_rx), .dec_ry(dec_ry), .dec_use_imm(dec_use_imm),
    .dec_imm(dec_imm), .dec_cond(dec_cond), .dec_part_x(dec_part_x), .dec_part_y(dec_part_y),
    .dec_ssrf_bit(dec_ssrf_bit), .tgt_ext_misaligned(tgt_ext_misaligned),
    .dec_ready(dec_ready), .issue(issue), .illegal_op(illegal_op), .pc_load(pc_load),
    .pc_target(pc_target), .ex_result(ex_result), .flags_q(flags_q),
    .issue_latency(issue_latency)
  );
  // first revision copy only shows which ops it refuses
  alu_issue_timing #(.REVISION(1)) alu_issue_timing_r1_i (
    .clk(clk), .nrst(nrst), .ce(ce), .dec_valid(dec_valid), .dec_op(dec_op),
    .dec_rd(dec_rd), .dec_rx(dec_rx), .dec_ry(dec_ry), .dec_use_imm(dec_use_imm),
    .dec_imm(dec_imm), .dec_cond(dec_cond), .dec_part_x(dec_part_x), .dec_part_y(dec_part_y),
    .dec_ssrf_bit(dec_ssrf_bit), .tgt_ext_misaligned(tgt_ext_misaligned),
    .dec_ready(), .issue(), .illegal_op(ill1), .pc_load(), .pc_target(), .ex_result(),
    .flags_q(), .issue_latency()
  );
  always #2 clk = ~clk;
  // ****************
  // expectation helpers
  // ****************
  function automatic logic [31:0] sx(logic [31:0] v, logic p);
    return p ? {{16{v[31]}}, v[31:16]} : {{16{v[15]}}, v[15:0]};
  endfunction
  function automatic logic [31:0] ab(logic [31:0] v);
    return v[31] ? 32'h0 - v : v;
  endfunction
  function automatic logic [31:0] model(alu_op_t op, logic [31:0] a, logic [31:0] b,
    logic c, logic px, logic py);
    case (op)
      OP_SUB: return a - b;
      OP_ADC: return a + b + 32'(c);
      OP_SBC: return a - b - 32'(c);
      OP_ACR: return a + 32'(c);
      OP_SCR: return a - 32'(c);
      OP_ADDHH: return sx(a, px) + sx(b, py);
      OP_ADDABS: return a + ab(b);
      OP_MAX: return $signed(a) > $signed(b) ? a : b;
      OP_MIN: return $signed(a) < $signed(b) ? a : b;
      OP_NEG: return 32'h0 - a;
      OP_ABS: return ab(a);
      OP_RSUB, OP_RSUB_COND: return b - a;
      default: return a + b;
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // holds the request until issue is seen, returns just after the taking edge
  task automatic exec(alu_op_t op, logic [3:0] rd, logic [3:0] rx, logic [3:0] ry,
    logic ui, logic [31:0] imm, logic [3:0] cond);
    int n;
    n = 0;
    dec_op = op;
    dec_rd = rd;
    dec_rx = rx;
    dec_ry = ry;
    dec_use_imm = ui;
    dec_imm = imm;
    dec_cond = cond;
    dec_valid = 1'b1;
    #1;
    while (issue !== 1'b1 && n < 16) begin
      @(posedge clk);
      #2;
      n++;
    end
    waited = n;
    lat_seen = issue_latency;
    chk("issue", 32'h1, 32'(issue));
    chk("illegal_op", 32'h0, 32'(illegal_op));
    chk("illegal_op_r1", 32'(op == OP_ADD_COND || op == OP_RSUB_COND), 32'(ill1));
    @(posedge clk);
    #1;
  endtask
  task automatic rd1;
    exec(OP_ADD, 4'hd, 4'h1, 4'h0, 1'b1, 32'h0, 4'hf);
  endtask
  initial begin
    #(4 * 8000);
    error_cnt++;
    conclude();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [31:0] a, b, ci, k, e, m1;
    logic c, wr;
    void'($urandom(9180));
    repeat (16) @(posedge clk);
    #1;
    chk("reset_ready", 32'h1, 32'(dec_ready));
    chk("reset_lat", 32'h0, 32'(issue_latency));
    chk("reset_pc_load", 32'h0, 32'(pc_load));
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    for (int r = 0; r < 4; r++) begin
      foreach (ops[i]) begin
        a = r == 0 ? 32'h80000000 : $urandom;
        b = r == 0 ? 32'hffffffff : $urandom;
        ci = $urandom;
        c = 1'(({1'b0, a} + {1'b0, ci}) >> 32);
        dec_part_x = 1'($urandom);
        dec_part_y = 1'($urandom);
        exec(OP_ADD, 4'h1, 4'h0, 4'h0, 1'b1, a, 4'hf);
        exec(OP_ADD, 4'h2, 4'h0, 4'h0, 1'b1, b, 4'hf);
        exec(OP_ADD, 4'h3, 4'h1, 4'h0, 1'b1, ci, 4'hf);
        exec(ops[i], 4'h1, 4'h1, 4'h2, ops[i] == OP_RSUB_COND, b, cnd[i]);
        wr = !(ops[i] inside {OP_CP_B, OP_CP_H, OP_CP_W, OP_CPC}) &&
          (cnd[i] == `COND_AL || (cnd[i] == `COND_CS && c));
        e = wr ? model(ops[i], a, b, c, dec_part_x, dec_part_y) : a;
        if (wr) chk("ex_result", e, ex_result);
        rd1();
        chk("latency", 32'h1, 32'(lat_seen));
        chk("forwarded", e, ex_result);
        m1 = e;
      end
    end
    exec(OP_CP_W, 4'h1, 4'h1, 4'h1, 1'b0, 32'h0, 4'hf);
    chk("zero_flag", 32'h1, 32'(flags_q[`FLAG_Z]));
    chk("borrow_flag", 32'h0, 32'(flags_q[`FLAG_C]));
    foreach (cnd[i]) begin
      if (i < 3) begin
        dec_ssrf_bit = i == 0 ? 5'h0e : (i == 1 ? 5'h0f : 5'h1f);
        exec(OP_SSRF, 4'hc, 4'h1, 4'h1, 1'b0, 32'h0, 4'hf);
        rd1();
        chk("ssrf_stall", 32'(i > 0), 32'(waited));
        chk("ssrf_lat", 32'(i > 0) + 32'h1, 32'(lat_seen));
      end
    end
    for (int mis = 0; mis < 2; mis++) begin
      k = $urandom;
      tgt_ext_misaligned = 1'(mis);
      exec(OP_ADD, 4'hf, 4'h1, 4'h0, 1'b1, k, 4'hf);
      chk("pc_load", 32'h1, 32'(pc_load));
      chk("pc_target", m1 + k, pc_target);
      chk("flush_ready", 32'h0, 32'(dec_ready));
      @(posedge clk);
      #1;
      chk("pc_load_end", 32'h0, 32'(pc_load));
      rd1();
      chk("flush_wait", 32'(mis) + 32'h1, 32'(waited));
      chk("pc_lat", 32'(mis) + 32'h3, 32'(lat_seen));
      tgt_ext_misaligned = 1'b0;
    end
    // enable low for two edges holds the request back
    ce = 1'b0;
    fork
      begin
        repeat (2) @(posedge clk);
        #1;
        ce = 1'b1;
      end
    join_none
    k = $urandom;
    exec(OP_ADD, 4'h4, 4'h0, 4'h0, 1'b1, k, 4'hf);
    chk("ce_wait", 32'h2, 32'(waited));
    chk("ce_result", k, ex_result);
    dec_valid = 1'b0;
    conclude();
  end
endmodule
`default_nettype wire
